/* hw/fpt_pkg.sv */
// Package for the five-channel PWM timer: register map, field layout, timer count.
// Assumes an AHB-Lite slave with 32-bit data and word-aligned registers.
package fpt_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] PRESCALE_CFG_OFF = 8'h00;  // prescaler_config_register
  localparam logic [7:0] DIVIDER_CFG_OFF  = 8'h04;  // divider_config_register
  localparam logic [7:0] TIMER_CTRL_OFF   = 8'h08;  // timer_control_register
  localparam logic [7:0] TIMER_BASE_OFF   = 8'h0C;  // First per-timer block
  localparam logic [7:0] TIMER_STRIDE     = 8'h0C;  // Reload, compare, observe
  localparam logic [7:0] STATUS_OFF       = 8'h48;  // Pending events, write 1 to clear
  localparam logic [1:0] SUB_RELOAD       = 2'h0;
  localparam logic [1:0] SUB_COMPARE      = 2'h1;
  localparam logic [1:0] SUB_OBSERVE      = 2'h2;
  // ==========================================================================
  // Field layout
  localparam int PRE0_LSB      = 0;   // Prescaler for timers 0 and 1
  localparam int PRE1_LSB      = 8;   // Prescaler for timers 2 to 4
  localparam int DEAD_LSB      = 16;  // Dead-zone length in prescaler ticks
  localparam int DMA_MODE_LSB  = 20;  // In divider_config_register
  localparam int CTRL_STRIDE   = 4;   // Control bits per timer
  localparam int CTRL_START    = 0;
  localparam int CTRL_UPDATE   = 1;
  localparam int CTRL_INVERT   = 2;
  localparam int CTRL_RELOAD   = 3;
  localparam int CTRL_DEAD_EN  = 20;
  localparam int NUM_TIMERS    = 5;
  localparam logic [3:0] DMA_NONE = 4'h0;
endpackage : fpt_pkg

/* hw/fpt_timer.sv */
// Five-channel PWM timer with shared prescalers, per-timer dividers,
// double-buffered reload/compare, dead zone on timer 0 and DMA selection.
// Assumes a single-master AHB-Lite bus on the same clock; hsel qualifies.
//
// Overview of operation
// R1: Five 16-bit timers, timers 0-3 PWM
// R2: Timer 4 internal, drives no pin
// R3: Timer 0 dead-zone generator, complementary outputs
// R4: Prescaler A timers 0-1, B timers 2-4
// R5: Per-timer divider selects 2, 4, 8, 16
// R6: Prescaler value 0 to 255 from config
// R7: Start loads counter from reload buffer; here manual update or auto-reload at zero loads it, start alone does not
// R8: Compare buffer copied to internal compare register
// R9: Count down per tick; zero raises request
// R10: Auto-reload copies buffer at zero
// R11: Stopping by enable clear never reloads
// R12: Output toggles when counter equals compare
// R13: Auto-reload and one-shot modes supported
// R14: Reload buffer accepts full 16-bit range
// R15: Tick = clock / (prescale+1) / divider
// R16: Manual update copies both buffers continuously
// R17: DMA mode selects timer, suppresses its interrupt
// R18: Dead-zone outputs never both active
// R19: Decrement exactly one; hold when disabled
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module fpt_timer (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Timer outputs
  output logic      [3:0]  o_pwm_out,
  output logic             o_complementary_deadband_output,
  output logic      [4:0]  o_irq,
  output logic             o_dma_req,
  // DMA acknowledge, same clock domain
  input  wire logic        i_dma_ack
);
  localparam int N = fpt_pkg::NUM_TIMERS;
  // ==========================================================================
  // Bus address phase capture
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [31:0] prescale_cfg, divider_cfg, timer_ctrl;
  logic [15:0] reload_buf [N];
  logic [15:0] compare_buf [N];
  logic [15:0] counter [N];
  logic [15:0] compare_reg [N];
  logic [N-1:0] tout, pend;
  logic        pre_tick0, pre_tick1, dead_tick;
  logic [7:0]  pre_cnt0, pre_cnt1;
  logic [N-1:0] tick;
  logic [3:0]  div_cnt [N];
  logic [3:0]  dma_mode;
  wire         bus_take = i_hsel && i_hready && i_htrans[1];
  assign dma_mode = divider_cfg[fpt_pkg::DMA_MODE_LSB +: 4];

  // Address phase latched; writes land in the data phase (zero wait state)
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (i_hready) begin
      wr_pend <= bus_take && i_hwrite;
      wr_addr <= i_haddr;
    end
  end

  // Read data registered at the address phase, valid in the data phase
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (bus_take && !i_hwrite) begin
      o_hrdata <= 32'h0000_0000;
      case (i_haddr)
        fpt_pkg::PRESCALE_CFG_OFF: o_hrdata <= prescale_cfg;
        fpt_pkg::DIVIDER_CFG_OFF:  o_hrdata <= divider_cfg;
        fpt_pkg::TIMER_CTRL_OFF:   o_hrdata <= timer_ctrl;
        fpt_pkg::STATUS_OFF:       o_hrdata <= {27'h0, pend};
        default: begin
          for (int t = 0; t < N; t++) begin
            if (i_haddr == 8'(fpt_pkg::TIMER_BASE_OFF + t * fpt_pkg::TIMER_STRIDE))
              o_hrdata <= {16'h0, reload_buf[t]};
            if (i_haddr == 8'(fpt_pkg::TIMER_BASE_OFF + t * fpt_pkg::TIMER_STRIDE + 4))
              o_hrdata <= {16'h0, compare_buf[t]};
            if (i_haddr == 8'(fpt_pkg::TIMER_BASE_OFF + t * fpt_pkg::TIMER_STRIDE + 8))
              o_hrdata <= {16'h0, counter[t]};  // Observation of live counter
          end
        end
      endcase
    end
  end

  // Always ready, always OKAY; unmapped addresses read zero, writes dropped
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      prescale_cfg <= 32'h0000_0000;
      divider_cfg  <= 32'h0000_0000;
      timer_ctrl   <= 32'h0000_0000;
    end else if (wr_pend) begin
      if (wr_addr == fpt_pkg::PRESCALE_CFG_OFF) prescale_cfg <= i_hwdata;  // R6
      if (wr_addr == fpt_pkg::DIVIDER_CFG_OFF)  divider_cfg  <= i_hwdata;
      if (wr_addr == fpt_pkg::TIMER_CTRL_OFF)   timer_ctrl   <= i_hwdata;
    end
  end

  // Reload and compare buffers, full 16-bit range
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (int t = 0; t < N; t++) begin
        reload_buf[t]  <= 16'h0000;
        compare_buf[t] <= 16'h0000;
      end
    end else if (wr_pend) begin
      for (int t = 0; t < N; t++) begin
        if (wr_addr == 8'(fpt_pkg::TIMER_BASE_OFF + t * fpt_pkg::TIMER_STRIDE))
          reload_buf[t] <= i_hwdata[15:0];  // R14
        if (wr_addr == 8'(fpt_pkg::TIMER_BASE_OFF + t * fpt_pkg::TIMER_STRIDE + 4))
          compare_buf[t] <= i_hwdata[15:0];
      end
    end
  end

  // ==========================================================================
  // Prescalers: a pulse every (value+1) clocks
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      pre_cnt0  <= 8'h00;
      pre_cnt1  <= 8'h00;
      pre_tick0 <= 1'b0;
      pre_tick1 <= 1'b0;
    end else begin
      pre_tick0 <= (pre_cnt0 == 8'h00);  // R4 R15
      pre_tick1 <= (pre_cnt1 == 8'h00);  // R4 R15
      pre_cnt0  <= (pre_cnt0 == 8'h00) ? prescale_cfg[fpt_pkg::PRE0_LSB +: 8] : pre_cnt0 - 8'h01;
      pre_cnt1  <= (pre_cnt1 == 8'h00) ? prescale_cfg[fpt_pkg::PRE1_LSB +: 8] : pre_cnt1 - 8'h01;
    end
  end

  // Dividers: select 2, 4, 8 or 16 prescaler pulses per tick
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (int t = 0; t < N; t++) begin
        div_cnt[t] <= 4'h0;
        tick[t]    <= 1'b0;
      end
    end else begin
      for (int t = 0; t < N; t++) begin
        logic pt;
        logic [3:0] lim;
        pt  = (t < 2) ? pre_tick0 : pre_tick1;
        lim = 4'((2 << divider_cfg[t*4 +: 2]) - 1);  // R5
        tick[t] <= 1'b0;
        if (pt) begin
          div_cnt[t] <= (div_cnt[t] >= lim) ? 4'h0 : div_cnt[t] + 4'h1;
          tick[t]    <= (div_cnt[t] >= lim);  // R15
        end
      end
    end
  end

  // ==========================================================================
  // Down counters, compare registers and toggle outputs
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      for (int t = 0; t < N; t++) begin
        counter[t]     <= 16'h0000;
        compare_reg[t] <= 16'h0000;
        tout[t]        <= 1'b0;
      end
    end else begin
      for (int t = 0; t < N; t++) begin
        logic en, upd, arl;
        en  = timer_ctrl[t*fpt_pkg::CTRL_STRIDE + fpt_pkg::CTRL_START];
        upd = timer_ctrl[t*fpt_pkg::CTRL_STRIDE + fpt_pkg::CTRL_UPDATE];
        arl = timer_ctrl[t*fpt_pkg::CTRL_STRIDE + fpt_pkg::CTRL_RELOAD];
        if (upd) begin
          counter[t]     <= reload_buf[t];   // R16 R7
          compare_reg[t] <= compare_buf[t];  // R8
          tout[t]        <= 1'b0;
        end else if (en && tick[t]) begin    // R11 R19: no reload path when stopped
          if (counter[t] == 16'h0000) begin
            if (arl) begin
              counter[t]     <= reload_buf[t];   // R10 R13
              compare_reg[t] <= compare_buf[t];  // R8
              tout[t]        <= 1'b0;
            end                                   // R13: one-shot stays at zero
          end else begin
            counter[t] <= counter[t] - 16'h0001;  // R9 R19
            if (counter[t] - 16'h0001 == compare_reg[t])
              tout[t] <= ~tout[t];                // R12
          end
        end
      end
    end
  end

  // Zero reached: interrupt pulse unless selected for DMA, sticky pending bit
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_irq <= '0;
      pend  <= '0;
    end else begin
      for (int t = 0; t < N; t++) begin
        logic hit;
        hit = timer_ctrl[t*fpt_pkg::CTRL_STRIDE] && tick[t] && counter[t] == 16'h0001;
        o_irq[t] <= hit && (dma_mode != 4'(t + 1));  // R9 R17
        // Set wins over a same-cycle write-one-to-clear
        if (hit)
          pend[t] <= 1'b1;
        else if (wr_pend && wr_addr == fpt_pkg::STATUS_OFF && i_hwdata[t])
          pend[t] <= 1'b0;
      end
    end
  end

  // DMA request held until acknowledged; a new request in the ack cycle wins so none is lost
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_dma_req <= 1'b0;
    end else begin
      if (i_dma_ack)
        o_dma_req <= 1'b0;
      for (int t = 0; t < N; t++)
        if (dma_mode == 4'(t + 1) && timer_ctrl[t*fpt_pkg::CTRL_STRIDE] && tick[t] && counter[t] == 16'h0001)
          o_dma_req <= 1'b1;  // R17
    end
  end

  // ==========================================================================
  // Dead zone on timer 0: delay each rising edge by a programmed gap
  logic [3:0] dead_cnt;
  logic       t0_pol, t0_prev;
  assign dead_tick = pre_tick0;
  assign t0_pol = tout[0] ^ timer_ctrl[fpt_pkg::CTRL_INVERT];
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      dead_cnt  <= 4'h0;
      t0_prev   <= 1'b0;
      o_pwm_out <= 4'h0;
      o_complementary_deadband_output <= 1'b0;
    end else begin
      t0_prev <= t0_pol;
      for (int t = 1; t < 4; t++)  // R1 R2: timer 4 has no pin
        o_pwm_out[t] <= tout[t] ^ timer_ctrl[t*fpt_pkg::CTRL_STRIDE + fpt_pkg::CTRL_INVERT];
      if (!timer_ctrl[fpt_pkg::CTRL_DEAD_EN]) begin
        o_pwm_out[0] <= t0_pol;
        o_complementary_deadband_output <= ~t0_pol;
      end else if (t0_pol != t0_prev) begin
        // Both off for the gap; prevents shoot-through in the power stage
        o_pwm_out[0] <= 1'b0;  // R3 R18
        o_complementary_deadband_output <= 1'b0;  // R18
        dead_cnt <= prescale_cfg[fpt_pkg::DEAD_LSB +: 4];
      end else if (dead_cnt != 4'h0) begin
        if (dead_tick) dead_cnt <= dead_cnt - 4'h1;
      end else begin
        o_pwm_out[0] <= t0_pol;  // R3
        o_complementary_deadband_output <= ~t0_pol;
      end
    end
  end

  // ==========================================================================
  // Assertions
  a_dead_exclusive: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R18
    timer_ctrl[fpt_pkg::CTRL_DEAD_EN] && !$past(o_pwm_out[0] && o_complementary_deadband_output)
    |-> !(o_pwm_out[0] && o_complementary_deadband_output))
    else $error("dead-zone outputs both active");
  a_dead_gap: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R3
    timer_ctrl[fpt_pkg::CTRL_DEAD_EN] && $changed(tout[0]) && $stable(timer_ctrl[fpt_pkg::CTRL_INVERT])
    |=> !o_pwm_out[0] && !o_complementary_deadband_output)
    else $error("dead-zone gap missing after edge");
  a_count_step: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R19 R9
    timer_ctrl[0] && !timer_ctrl[1] && tick[0] && counter[0] != 16'h0000
    |=> counter[0] == $past(counter[0]) - 16'h0001)
    else $error("counter did not step by one");
  a_hold_stopped: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R11
    !timer_ctrl[0] && !timer_ctrl[1] |=> counter[0] == $past(counter[0]))
    else $error("stopped counter changed");
  a_auto_reload: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R10
    timer_ctrl[0] && timer_ctrl[3] && !timer_ctrl[1] && tick[0] && counter[0] == 16'h0000
    |=> counter[0] == $past(reload_buf[0]))
    else $error("auto-reload missed");
  a_one_shot: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R13
    !timer_ctrl[3] && !timer_ctrl[1] && counter[0] == 16'h0000 |=> counter[0] == 16'h0000)
    else $error("one-shot timer restarted");
  a_manual_upd: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R16 R8
    timer_ctrl[1] |=> counter[0] == $past(reload_buf[0]) && compare_reg[0] == $past(compare_buf[0]))
    else $error("manual update did not copy buffers");
  a_irq_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R9
    o_irq[0] |-> counter[0] == 16'h0000)
    else $error("interrupt without zero count");
  a_dma_no_irq: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R17
    $past(dma_mode) == 4'h1 |-> !o_irq[0])
    else $error("DMA-selected timer raised interrupt");
  a_tick_gap: assert property (@(posedge i_clock) disable iff (i_sys_rst)  // R5
    tick[0] |=> !tick[0])
    else $error("divider tick too fast");
  c_reload: cover property (@(posedge i_clock) disable iff (i_sys_rst) o_irq[0] && timer_ctrl[3]);
  c_dma: cover property (@(posedge i_clock) disable iff (i_sys_rst) o_dma_req && i_dma_ack);
  c_dead: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    timer_ctrl[fpt_pkg::CTRL_DEAD_EN] && $rose(o_complementary_deadband_output));
endmodule : fpt_timer

/* verif/fpt_host_model.sv */
// Far-side model: interrupt counter of the CPU and acknowledge side of DMA.
// Assumes the timer's clock and a sync active-high reset; ack is a level.
`timescale 1ns/1ps
module fpt_host_model (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_sys_rst,
  // Requests from the timer
  input  wire logic [4:0] i_irq,
  input  wire logic       i_dma_req,
  // Acknowledge delay in cycles, zero answers promptly
  input  wire logic [7:0] i_ack_delay,
  output logic            o_dma_ack
);
  logic [7:0] irq_cnt [5];
  logic [7:0] wait_cnt;
  // ==========================================================================
  // Interrupt pulse counters, one per timer
  always_ff @(posedge i_clock) begin
    for (int t = 0; t < 5; t++) begin
      if (i_sys_rst) begin
        irq_cnt[t] <= 8'h00;
      end else if (i_irq[t]) begin
        irq_cnt[t] <= irq_cnt[t] + 8'h01;
      end
    end
  end
  // ==========================================================================
  // Ack after a delay; held until the request drops so no request is lost
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || !i_dma_req) begin
      wait_cnt  <= 8'h00;
      o_dma_ack <= 1'b0;
    end else if (wait_cnt == i_ack_delay) begin
      o_dma_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
endmodule : fpt_host_model

/* verif/test_five_channel_pwm_timer.sv */
// Testbench: AHB-Lite register calls with expected periods, modes and reads.
// Assumes waits follow hready; the host model counts interrupts and acks DMA.
`timescale 1ns/1ps
module test_five_channel_pwm_timer;
  logic        i_clock;
  logic        i_sys_rst;
  logic        i_hsel;
  logic [7:0]  i_haddr;
  logic [1:0]  i_htrans;
  logic        i_hwrite;
  logic [2:0]  i_hsize;
  logic [31:0] i_hwdata;
  logic [31:0] o_hrdata;
  logic        o_hreadyout;
  logic        o_hresp;
  logic [3:0]  o_pwm_out;
  logic        o_cdo;
  logic [4:0]  o_irq;
  logic        o_dma_req;
  logic        dma_ack;
  logic [7:0]  ack_delay;
  logic [31:0] q;
  logic [31:0] q2;
  int          error_cnt;
  int          check_count;
  int          dma_rise = 0;
  logic [3:0]  flips;
  logic        dma_prev;
  logic [7:0]  snap;

  fpt_timer i_fpt_timer (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .o_pwm_out(o_pwm_out), .o_complementary_deadband_output(o_cdo), .o_irq(o_irq),
    .o_dma_req(o_dma_req), .i_dma_ack(dma_ack));
  fpt_host_model i_fpt_host_model (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_irq(o_irq),
    .i_dma_req(o_dma_req), .i_ack_delay(ack_delay), .o_dma_ack(dma_ack));

  // ==========================================================================
  // Clock, 4 ns period
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  // Count DMA request rising edges
  always @(posedge i_clock) begin
    dma_prev <= o_dma_req;
    if (o_dma_req === 1'b1 && dma_prev === 1'b0) dma_rise <= dma_rise + 1;
  end
  // ==========================================================================
  // Bus and compare tasks
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    // Start right after a rising edge; only the watchdog ends a wait
    @(posedge i_clock);
    i_hsel   <= 1'b1;
    i_haddr  <= a;
    i_hwrite <= w;
    i_htrans <= 2'h2;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hsel   <= 1'b0;
    i_hwdata <= d;
    do @(posedge i_clock); while (o_hreadyout !== 1'b1);
    r = o_hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk
  // Cycles between two interrupt pulses of timer t, sampled mid-cycle
  task automatic period(input int t, input int e);
    int c;
    c = 0;
    do @(negedge i_clock); while (o_irq[t] !== 1'b1 && ++c < 3000);
    c = 0;
    do begin @(negedge i_clock); c++; end while (o_irq[t] !== 1'b1 && c < 3000);
    chk("irq period", 32'(e), 32'(c));
  endtask : period
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Watchdog well above the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge i_clock);
    $display("MISMATCH watchdog expected done seen hang");
    error_cnt++;
    test_done();
  end
  // ==========================================================================
  // Test sequence
  initial begin
    i_sys_rst = 1'b1;
    {i_hsel, i_haddr, i_htrans, i_hwrite, i_hwdata} = '0;
    i_hsize = 3'h2;
    ack_delay = 8'h03;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(negedge i_clock);
    chk("outputs after reset", 32'h1, {o_pwm_out, o_cdo, o_irq, o_dma_req, o_hresp, o_hreadyout});
    $display("test reset done");
    // Full 16-bit reload, unmapped read, config readback
    wr(8'h0C, 32'h0000FFFF);
    bus(8'h0C, 1'b0, 32'h0, q);
    chk("reload max", 32'h0000FFFF, q);
    bus(8'h4C, 1'b0, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    wr(8'h00, 32'h00030102);
    bus(8'h00, 1'b0, 32'h0, q);
    chk("prescale readback", 32'h00030102, q);
    $display("test registers done");
    // Five timers: pre A=2, pre B=1; dividers t0 /2, t1 /4, t4 /16
    wr(8'h04, 32'h00030010);
    for (int t = 0; t < 5; t++) wr(8'(8'h0C + 12 * t), 32'(t == 0 ? 4 : (t == 4 ? 3 : 2)));
    wr(8'h10, 32'h2);
    wr(8'h08, 32'h00022222);
    wr(8'h08, 32'h00099999);
    period(0, 5 * 2 * 3);
    period(1, 3 * 4 * 3);
    period(4, 4 * 16 * 2);
    q = 0;
    q2 = 0;
    flips = 4'h0;
    snap = {4'h0, o_pwm_out};
    repeat (60) begin
      @(negedge i_clock);
      if (o_pwm_out[0] !== snap[0]) q++;
      if (o_cdo !== ~o_pwm_out[0]) q2++;
      flips = flips | (o_pwm_out ^ snap[3:0]);
      snap = {4'h0, o_pwm_out};
    end
    chk("pwm0 toggles", 32'h1, {31'h0, q > 0});
    chk("complement output", 32'h0, q2);
    chk("pwm pins toggle", 32'hF, {28'h0, flips});
    // Dead zone on: never both high, and at least one gap with both low
    wr(8'h08, 32'h00199999);
    q = 0;
    q2 = 0;
    repeat (90) begin
      @(negedge i_clock);
      if ((o_pwm_out[0] & o_cdo) !== 1'b0) q++;
      if ({o_pwm_out[0], o_cdo} === 2'b00) q2++;
    end
    chk("dead zone overlap", 32'h0, q);
    chk("dead zone gap", 32'h1, {31'h0, q2 > 0});
    $display("test periods done");
    // Every DMA mode: selected timer requests and stays silent
    for (int m = 1; m < 6; m++) begin
      wr(8'h04, 32'h00030010 | (m << 20));
      // Let a pulse launched under the old mode reach the counter first
      repeat (2) @(negedge i_clock);
      snap = i_fpt_host_model.irq_cnt[m - 1];
      q = 32'(dma_rise);
      repeat (300) @(posedge i_clock);
      chk("irq while dma", 32'(snap), 32'(i_fpt_host_model.irq_cnt[m - 1]));
      chk("dma request seen", 32'h1, {31'h0, dma_rise > q});
    end
    wr(8'h04, 32'h00030010);
    snap = i_fpt_host_model.irq_cnt[4];
    repeat (300) @(posedge i_clock);
    chk("irq with mode none", 32'h1, {31'h0, i_fpt_host_model.irq_cnt[4] != snap});
    $display("test dma done");
    // Stop timer 0: counter holds and is not reloaded
    wr(8'h08, 32'h00099998);
    bus(8'h14, 1'b0, 32'h0, q);
    snap = i_fpt_host_model.irq_cnt[0];
    repeat (50) @(posedge i_clock);
    bus(8'h14, 1'b0, 32'h0, q2);
    chk("stopped counter", q, q2);
    chk("stopped irq", 32'(snap), 32'(i_fpt_host_model.irq_cnt[0]));
    // Invert on a stopped timer flips both pins of timer 0
    @(negedge i_clock);
    q = {31'h0, o_pwm_out[0]};
    wr(8'h08, 32'h0009999C);
    repeat (2) @(negedge i_clock);
    chk("inverted pwm0", {31'h0, ~q[0]}, {31'h0, o_pwm_out[0]});
    chk("inverted complement", {31'h0, q[0]}, {31'h0, o_cdo});
    // One-shot: one zero event, then stays at zero
    wr(8'h08, 32'h0009999A);
    wr(8'h08, 32'h00099991);
    repeat (200) @(posedge i_clock);
    chk("one-shot irqs", 32'(snap + 8'h01), 32'(i_fpt_host_model.irq_cnt[0]));
    bus(8'h14, 1'b0, 32'h0, q);
    chk("one-shot counter", 32'h0, q);
    // Pending bit of timer 0 is sticky and clears on write-one
    bus(8'h48, 1'b0, 32'h0, q);
    chk("pending timer0", 32'h1, {31'h0, q[0]});
    wr(8'h48, 32'h00000001);
    bus(8'h48, 1'b0, 32'h0, q);
    chk("pending cleared", 32'h0, {31'h0, q[0]});
    $display("test stop and one-shot done");
    test_done();
  end
endmodule : test_five_channel_pwm_timer
